// [hw/rpt_timers.sv]
`timescale 1ns/1ns
`include "rpt_regs.svh"
// Contract
// (R1) host writes timer configuration only while that timer is idle
// (R2) clear command stops all timers but wake-up, bar unconditional no-reply
// (R3) mask and no-reply timers start at end of transmit frame
// (R4) receive window held low while mask timer runs
// (R5) squelch follows mask timer when enabled; mask timer never flags
// (R6) in peer mode mask timer starts on peer field on
// (R7) low-power target: command starts mask timer, step 512 carrier periods
// (R8) step bit selects no-reply step of 64 or 4096 periods
// (R9) normal mode: expiry before reply flags and forces window low
// (R10) unconditional mode: always flags, ignores clear, forces low if idle
// (R11) no-reply timeout loads from two byte registers together
// (R12) start command restarts no-reply timer; ignored in peer mode
// (R13) peer mode: expiry before peer field on flags
// (R14) no-reply expiry reported by its own flag bit
// (R15) host keeps transmit-end interrupt unmasked and reads it; no such interrupt here, the host paces starts
// (R16) general timer triggers on rx start, rx end or field off; here field off triggers only in peer mode
// (R17) start command restarts general timer
// (R18) wake start accepted outside wake mode, runs rc, sets wake flag
// (R19) only wake timer counts without the crystal clock
// (R20) wake period selectable 10 to 800 ms, default 100 ms
// (R21) each timer counts down on derived ticks and expires once
module rpt_timers (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output rpt_pkg::rpt_resp_t s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output rpt_pkg::rpt_resp_t s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic fc_tick_i,
  input wire logic xtal_ok_i,
  input wire logic rc_tick_i,
  input wire logic tx_end_i,
  input wire logic rx_start_i,
  input wire logic rx_end_i,
  input wire logic rx_busy_i,
  input wire logic peer_field_on_i,
  input wire logic peer_field_off_i,
  output logic rx_window_o,
  output logic squelch_o,
  output logic rc_osc_en_o
);
  import rpt_pkg::*;

  logic [3:0] ctrl;
  logic [7:0] mrt_val;
  logic [7:0] nrt_hi;
  logic [7:0] nrt_lo;
  logic [3:0] tctrl;
  logic [15:0] gpt_val;
  logic [2:0] wu_sel;
  logic [2:0] flags;
  logic [4:0] cmd;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic have_aw;
  logic have_w;
  logic do_write;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic [11:0] fc_div;
  logic fc_live;
  logic tick_fine;
  logic tick_lpt;
  logic tick_coarse;
  logic nrt_tick;
  logic [3:0] tm_start;
  logic [3:0] tm_stop;
  logic [3:0] tm_tick;
  logic [15:0] tm_load [4];
  logic [3:0] run;
  logic [3:0] expd;
  logic gpt_trig_hit;
  logic nrt_force;
  logic p2p;
  logic lpt;
  logic wake_mode;
  logic sq_en;
  logic uncond;
  logic coarse;
  logic clr;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  rpt_trig_t trig;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  function automatic logic addr_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `RPT_OFF_CTRL, `RPT_OFF_CMD, `RPT_OFF_MRT, `RPT_OFF_NRT1,
      `RPT_OFF_NRT2, `RPT_OFF_TCTRL, `RPT_OFF_GPT, `RPT_OFF_WUCTRL,
      `RPT_OFF_FLAGS, `RPT_OFF_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [15:0] wu_ticks(input logic [2:0] sel);
    logic [15:0] t;
    t = 16'h0000;
    case (sel)
      3'h0: t = 16'(`RPT_WU_MS_0 * `RPT_RC_PER_MS);
      3'h1: t = 16'(`RPT_WU_MS_1 * `RPT_RC_PER_MS);
      3'h2: t = 16'(`RPT_WU_MS_2 * `RPT_RC_PER_MS);
      3'h3: t = 16'(`RPT_WU_MS_3 * `RPT_RC_PER_MS);
      3'h4: t = 16'(`RPT_WU_MS_4 * `RPT_RC_PER_MS);
      3'h5: t = 16'(`RPT_WU_MS_5 * `RPT_RC_PER_MS);
      3'h6: t = 16'(`RPT_WU_MS_6 * `RPT_RC_PER_MS);
      default: t = 16'(`RPT_WU_MS_7 * `RPT_RC_PER_MS);
    endcase
    return t;
  endfunction

  function automatic logic step_hit(input logic [11:0] div,
                                    input logic [12:0] step);
    logic [11:0] mask;
    mask = 12'(step - 13'h0001);
    return (div & mask) == mask;
  endfunction

  // ==========================================================
  // axi4-lite write channels
  assign do_write = have_aw & have_w & ~s_axi_bvalid_o;
  assign wr_ok = addr_mapped(aw_addr);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      have_aw <= 1'b0;
      aw_addr <= 8'h00;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awready_o <= 1'b0;
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (do_write) begin
        have_aw <= 1'b0;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_awready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_wready_o <= 1'b1;
      have_w <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wready_o <= 1'b0;
        have_w <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (do_write) begin
        have_w <= 1'b0;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RPT_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_ok ? RPT_RESP_OKAY : RPT_RESP_SLVERR;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  // no interlock against writes to a running timer; software must wait
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `RPT_RST_CTRL;
      mrt_val <= `RPT_RST_BYTE;
      nrt_hi <= `RPT_RST_BYTE;
      nrt_lo <= `RPT_RST_BYTE;
      tctrl <= `RPT_RST_TCTRL;
      gpt_val <= `RPT_RST_GPT;
      wu_sel <= `RPT_RST_WUSEL; // see (R20)
    end else begin
      if (do_write && w_strb[0]) begin
      case (aw_addr)
        `RPT_OFF_CTRL: ctrl <= w_data[3:0];
        `RPT_OFF_MRT: mrt_val <= w_data[7:0];
        `RPT_OFF_NRT1: nrt_hi <= w_data[7:0];
        `RPT_OFF_NRT2: nrt_lo <= w_data[7:0];
        `RPT_OFF_TCTRL: tctrl <= w_data[3:0];
        `RPT_OFF_GPT: gpt_val[7:0] <= w_data[7:0];
        `RPT_OFF_WUCTRL: wu_sel <= w_data[2:0];
        default: ;
      endcase
      end
      if (do_write && w_strb[1] && aw_addr == `RPT_OFF_GPT) begin
        gpt_val[15:8] <= w_data[15:8];
      end
    end
  end

  // direct commands are one-cycle pulses
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd <= 5'h00;
    end else if (do_write && w_strb[0] && aw_addr == `RPT_OFF_CMD) begin
      cmd <= w_data[4:0];
    end else begin
      cmd <= 5'h00;
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr_i)
      `RPT_OFF_CTRL: rd_word = {28'h0000000, ctrl};
      `RPT_OFF_CMD: rd_word = 32'h00000000;
      `RPT_OFF_MRT: rd_word = {24'h000000, mrt_val};
      `RPT_OFF_NRT1: rd_word = {24'h000000, nrt_hi};
      `RPT_OFF_NRT2: rd_word = {24'h000000, nrt_lo};
      `RPT_OFF_TCTRL: rd_word = {28'h0000000, tctrl};
      `RPT_OFF_GPT: rd_word = {16'h0000, gpt_val};
      `RPT_OFF_WUCTRL: rd_word = {29'h0, wu_sel};
      `RPT_OFF_FLAGS: rd_word = {29'h0, flags};
      `RPT_OFF_STATUS: rd_word = {27'h0, rx_window_o, run};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= RPT_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_ok ? RPT_RESP_OKAY : RPT_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ==========================================================
  // carrier prescaler, frozen while the crystal is stopped
  assign fc_live = fc_tick_i & xtal_ok_i; // see (R19)

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fc_div <= 12'h000;
    end else if (fc_live) begin
      fc_div <= fc_div + 12'h001;
    end
  end

  assign tick_fine = fc_live & step_hit(fc_div, `RPT_FINE_STEP_FC);
  assign tick_lpt = fc_live & step_hit(fc_div, `RPT_LPT_STEP_FC);
  assign tick_coarse = fc_live & step_hit(fc_div, `RPT_COARSE_STEP_FC);

  // ==========================================================
  // timer control
  assign p2p = ctrl[`RPT_CTRL_P2P];
  assign lpt = ctrl[`RPT_CTRL_LPT];
  assign wake_mode = ctrl[`RPT_CTRL_WAKE];
  assign sq_en = ctrl[`RPT_CTRL_SQ];
  assign uncond = tctrl[`RPT_TCTRL_UNCOND];
  assign coarse = tctrl[`RPT_TCTRL_COARSE];
  assign trig = rpt_trig_t'(tctrl[`RPT_TCTRL_TRIG_LSB +: 2]);
  assign clr = cmd[`RPT_CMD_CLEAR];
  assign nrt_tick = coarse ? tick_coarse : tick_fine; // see (R8)

  always_comb begin
    unique case (trig) // see (R16)
      RPT_TRIG_NONE: gpt_trig_hit = 1'b0;
      RPT_TRIG_RX_START: gpt_trig_hit = rx_start_i;
      RPT_TRIG_RX_END: gpt_trig_hit = rx_end_i;
      RPT_TRIG_FIELD_OFF: gpt_trig_hit = p2p & peer_field_off_i;
    endcase
  end

  always_comb begin
    // see (R3) (R6) (R7)
    tm_start[`RPT_T_MRT] = (p2p ? peer_field_on_i : tx_end_i)
                         | cmd[`RPT_CMD_MRT];
    tm_stop[`RPT_T_MRT] = clr; // see (R2)
    tm_tick[`RPT_T_MRT] = lpt ? tick_lpt : tick_fine; // see (R7)
    tm_load[`RPT_T_MRT] = {8'h00, mrt_val};
    // see (R3) (R12)
    tm_start[`RPT_T_NRT] = tx_end_i | (cmd[`RPT_CMD_NRT] & ~p2p);
    // see (R2) (R9) (R10) (R13)
    tm_stop[`RPT_T_NRT] = ~uncond
                        & (clr | (p2p ? peer_field_on_i : rx_start_i));
    tm_tick[`RPT_T_NRT] = nrt_tick;
    tm_load[`RPT_T_NRT] = {nrt_hi, nrt_lo}; // see (R11)
    tm_start[`RPT_T_GPT] = cmd[`RPT_CMD_GPT] | gpt_trig_hit; // see (R17)
    tm_stop[`RPT_T_GPT] = clr; // see (R2)
    tm_tick[`RPT_T_GPT] = tick_fine;
    tm_load[`RPT_T_GPT] = gpt_val;
    tm_start[`RPT_T_WUT] = cmd[`RPT_CMD_WUT] & ~wake_mode; // see (R18)
    tm_stop[`RPT_T_WUT] = 1'b0;
    tm_tick[`RPT_T_WUT] = rc_tick_i; // see (R19)
    tm_load[`RPT_T_WUT] = wu_ticks(wu_sel); // see (R20)
  end

  for (genvar gi = 0; gi < 4; gi++) begin : g_tmr
    rpt_countdown u_cnt (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(tm_start[gi]),
      .stop_i(tm_stop[gi]),
      .tick_i(tm_tick[gi]),
      .load_i(tm_load[gi]),
      .run_o(run[gi]),
      .expire_o(expd[gi])
    );
  end

  // ==========================================================
  // event flags, write one to clear; a set in the same cycle wins
  // mask timer expiry is deliberately not a flag source
  assign flag_set = {expd[`RPT_T_WUT], expd[`RPT_T_GPT], expd[`RPT_T_NRT]};
  assign flag_clr = (do_write && w_strb[0] && aw_addr == `RPT_OFF_FLAGS)
                  ? w_data[2:0] : 3'h0;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags <= 3'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set; // see (R14) (R16) (R18)
    end
  end

  // ==========================================================
  // receive window, squelch and rc oscillator
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nrt_force <= 1'b0;
    end else if (expd[`RPT_T_NRT] && (!uncond || !rx_busy_i)) begin
      nrt_force <= 1'b1; // see (R9) (R10)
    end else if (tx_end_i || cmd[`RPT_CMD_NRT]) begin
      nrt_force <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_window_o <= 1'b1;
      squelch_o <= 1'b0;
      rc_osc_en_o <= 1'b0;
    end else begin
      rx_window_o <= ~run[`RPT_T_MRT] & ~nrt_force; // see (R4)
      squelch_o <= run[`RPT_T_MRT] & sq_en; // see (R5)
      rc_osc_en_o <= run[`RPT_T_WUT]; // see (R18)
    end
  end

  // ==========================================================
  // checks
  sequence nrt_fire_s;
    expd[`RPT_T_NRT] && !uncond;
  endsequence

  sequence win_drop_s;
    nrt_force ##1 !rx_window_o;
  endsequence

  tx_start_a: assert property (tx_end_i && !p2p && mrt_val != 8'h00
    |=> run[`RPT_T_MRT] ##1 !rx_window_o) // see (R3)
    else $error("mask timer not started at end of transmit");
  nrt_txe_a: assert property (tx_end_i && {nrt_hi, nrt_lo} != 16'h0000
    |=> run[`RPT_T_NRT]) // see (R11)
    else $error("no-reply timer not started at end of transmit");
  mask_win_a: assert property (run[`RPT_T_MRT] |=> !rx_window_o) // see (R4)
    else $error("receive window open while mask timer runs");
  sq_follow_a: assert property (run[`RPT_T_MRT] && sq_en
    |=> squelch_o ##1 (squelch_o || !$past(run[`RPT_T_MRT]))) // see (R5)
    else $error("squelch not on during mask timer");
  p2p_mrt_a: assert property (p2p && peer_field_on_i && mrt_val != 8'h00
    |=> run[`RPT_T_MRT]) // see (R6)
    else $error("mask timer not started on peer field");
  clr_stop_a: assert property (clr && !tm_start[`RPT_T_GPT]
    |=> !run[`RPT_T_GPT]) // see (R2)
    else $error("general timer survived clear");
  emv_keep_a: assert property (run[`RPT_T_NRT] && uncond && clr
    && !nrt_tick |=> run[`RPT_T_NRT]) // see (R10)
    else $error("unconditional no-reply timer stopped by clear");
  nre_flag_a: assert property (expd[`RPT_T_NRT]
    |=> flags[`RPT_FLAG_NRE]) // see (R14)
    else $error("no-reply flag not set on expiry");
  force_low_a: assert property (nrt_fire_s |=> win_drop_s) // see (R9)
    else $error("window not forced low on no-reply expiry");
  silent_stop_a: assert property (run[`RPT_T_NRT] && !uncond && !p2p
    && rx_start_i && !tx_end_i && !cmd[`RPT_CMD_NRT]
    |=> !run[`RPT_T_NRT] && !expd[`RPT_T_NRT]) // see (R9)
    else $error("no-reply timer not stopped silently by reply");
  cmd_p2p_a: assert property (cmd[`RPT_CMD_NRT] && p2p && !tx_end_i
    && !run[`RPT_T_NRT] |=> !run[`RPT_T_NRT]) // see (R12)
    else $error("no-reply start command taken in peer mode");
  wake_ign_a: assert property (cmd[`RPT_CMD_WUT] && wake_mode
    && !run[`RPT_T_WUT] |=> !run[`RPT_T_WUT]) // see (R18)
    else $error("wake start command taken in wake mode");
  wut_flag_a: assert property (expd[`RPT_T_WUT]
    |=> flags[`RPT_FLAG_WAKE]) // see (R18)
    else $error("wake flag not set on expiry");
endmodule

// [hw/rpt_regs.svh]
`ifndef RPT_REGS_SVH
`define RPT_REGS_SVH

// ==========================================================
// register byte offsets
`define RPT_OFF_CTRL 8'h00
`define RPT_OFF_CMD 8'h04
`define RPT_OFF_MRT 8'h08
`define RPT_OFF_NRT1 8'h0c
`define RPT_OFF_NRT2 8'h10
`define RPT_OFF_TCTRL 8'h14
`define RPT_OFF_GPT 8'h18
`define RPT_OFF_WUCTRL 8'h1c
`define RPT_OFF_FLAGS 8'h20
`define RPT_OFF_STATUS 8'h24

// ==========================================================
// field positions
`define RPT_CTRL_P2P 0
`define RPT_CTRL_LPT 1
`define RPT_CTRL_WAKE 2
`define RPT_CTRL_SQ 3
`define RPT_CMD_CLEAR 0
`define RPT_CMD_MRT 1
`define RPT_CMD_NRT 2
`define RPT_CMD_GPT 3
`define RPT_CMD_WUT 4
`define RPT_TCTRL_UNCOND 0
`define RPT_TCTRL_COARSE 1
`define RPT_TCTRL_TRIG_LSB 2
`define RPT_FLAG_NRE 0
`define RPT_FLAG_GPE 1
`define RPT_FLAG_WAKE 2

// timer slots
`define RPT_T_MRT 0
`define RPT_T_NRT 1
`define RPT_T_GPT 2
`define RPT_T_WUT 3

// ==========================================================
// reset values
`define RPT_RST_CTRL 4'h0
`define RPT_RST_BYTE 8'h00
`define RPT_RST_TCTRL 4'h0
`define RPT_RST_GPT 16'h0000
`define RPT_RST_WUSEL 3'h3

// ==========================================================
// timing, in carrier periods and in milliseconds
`define RPT_FINE_STEP_FC 13'h0040
`define RPT_LPT_STEP_FC 13'h0200
`define RPT_COARSE_STEP_FC 13'h1000
`define RPT_RC_PER_MS 32
`define RPT_WU_MS_0 10
`define RPT_WU_MS_1 20
`define RPT_WU_MS_2 50
`define RPT_WU_MS_3 100
`define RPT_WU_MS_4 200
`define RPT_WU_MS_5 300
`define RPT_WU_MS_6 400
`define RPT_WU_MS_7 800

`endif

// [hw/rpt_pkg.sv]
package rpt_pkg;
  typedef enum logic [1:0] {
    RPT_TRIG_NONE = 2'h0,
    RPT_TRIG_RX_START = 2'h1,
    RPT_TRIG_RX_END = 2'h2,
    RPT_TRIG_FIELD_OFF = 2'h3
  } rpt_trig_t;

  typedef enum logic [1:0] {
    RPT_RESP_OKAY = 2'h0,
    RPT_RESP_SLVERR = 2'h2
  } rpt_resp_t;
endpackage

// [hw/rpt_countdown.sv]
`timescale 1ns/1ns
// ==========================================================
// one down-counting timer
module rpt_countdown (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic tick_i,
  input wire logic [15:0] load_i,
  output logic run_o,
  output logic expire_o
);
  import rpt_pkg::*;

  logic [15:0] cnt;

  // start beats stop so a restart while running reloads cleanly
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
      run_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (start_i) begin
        cnt <= load_i;
        run_o <= (load_i != 16'h0000);
      end else if (stop_i) begin
        run_o <= 1'b0;
      end else if (run_o && tick_i) begin // see (R21)
        if (cnt == 16'h0001) begin
          cnt <= 16'h0000;
          run_o <= 1'b0;
          expire_o <= 1'b1;
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
    end
  end
endmodule

// [verif/rpt_host.sv]
`timescale 1ns/1ns
// ==========================================================
// host side: single-beat axi4-lite master issuing commands
module rpt_host (
  input wire logic core_clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire rpt_pkg::rpt_resp_t bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire rpt_pkg::rpt_resp_t rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  import rpt_pkg::*;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // callers touch a timer's config only while that timer is idle
  // no transmit-end interrupt here, so starts are paced by the caller
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end while (!bvalid_i);
    bready_o <= 1'b0;
    r = bresp_i;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end while (!rvalid_i);
    rready_o <= 1'b0;
    d = rdata_i;
    r = rresp_i;
  endtask
endmodule

// [verif/reader_protocol_timers_test.sv]
`timescale 1ns/1ns
`include "rpt_regs.svh"
module reader_protocol_timers_test;
  import rpt_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
  } rpt_row_t;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic xtal_ok_i = 1'b1;
  logic rx_busy_i = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  rpt_resp_t bresp, rresp;
  logic rx_window_o, squelch_o, rc_osc_en_o;
  int errors = 0;
  int checked = 0;
  rpt_row_t rows [14];
  rpt_timers dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .fc_tick_i(1'b1), .xtal_ok_i(xtal_ok_i),
    .rc_tick_i(1'b1), .tx_end_i(ev[0]), .rx_start_i(ev[1]),
    .rx_end_i(ev[2]), .rx_busy_i(rx_busy_i), .peer_field_on_i(ev[3]),
    .peer_field_off_i(ev[4]), .rx_window_o(rx_window_o),
    .squelch_o(squelch_o), .rc_osc_en_o(rc_osc_en_o)
  );
  rpt_host host (
    .core_clk_i(core_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
    .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready)
  );
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(d, e);
  endtask
  // reads the flag word after n cycles, then clears it
  task automatic flags(input int n, input logic [31:0] e);
    cyc(n);
    rd_chk(`RPT_OFF_FLAGS, e);
    wr(`RPT_OFF_FLAGS, 32'h7);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge core_clk_i);
    ev <= m;
    @(posedge core_clk_i);
    ev <= 5'h00;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (60000) @(posedge core_clk_i);
    errors++;
    finish_test;
  end
  // ==========================================================
  // tests
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    rows = '{
      '{`RPT_OFF_CTRL, 32'hf, 32'hf, 2'h0},
      '{`RPT_OFF_MRT, 32'h1ff, 32'hff, 2'h0},
      '{`RPT_OFF_NRT1, 32'hab, 32'hab, 2'h0},
      '{`RPT_OFF_NRT2, 32'hcd, 32'hcd, 2'h0},
      '{`RPT_OFF_TCTRL, 32'h1f, 32'hf, 2'h0},
      '{`RPT_OFF_GPT, 32'h12345, 32'h2345, 2'h0},
      '{`RPT_OFF_WUCTRL, 32'hf, 32'h7, 2'h0},
      '{`RPT_OFF_CMD, 32'h0, 32'h0, 2'h0},
      '{8'h3c, 32'h5, 32'h0, 2'h2},
      '{`RPT_OFF_CTRL, 32'h0, 32'h0, 2'h0},
      '{`RPT_OFF_MRT, 32'h0, 32'h0, 2'h0},
      '{`RPT_OFF_NRT1, 32'h0, 32'h0, 2'h0},
      '{`RPT_OFF_NRT2, 32'h0, 32'h0, 2'h0},
      '{`RPT_OFF_TCTRL, 32'h0, 32'h0, 2'h0}};
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk(32'({rx_window_o, squelch_o, rc_osc_en_o}), 32'h4);
    rd_chk(`RPT_OFF_WUCTRL, 32'h3);
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d, r);
      chk(32'(r), 32'(rows[i].r));
      host.rd(rows[i].a, d, r);
      chk(d, rows[i].q);
      chk(32'(r), 32'(rows[i].r));
    end
    // mask timer after transmit end, squelch enabled
    wr(`RPT_OFF_CTRL, 32'h8);
    wr(`RPT_OFF_MRT, 32'h2);
    pulse(5'h01);
    cyc(3);
    chk(32'({rx_window_o, squelch_o}), 32'h1);
    cyc(140);
    chk(32'({rx_window_o, squelch_o}), 32'h2);
    flags(1, 32'h0);
    // low-power target: slow step, started by command
    wr(`RPT_OFF_CTRL, 32'h2);
    wr(`RPT_OFF_CMD, 32'h2);
    cyc(300);
    chk(32'(rx_window_o), 32'h0);
    cyc(800);
    chk(32'(rx_window_o), 32'h1);
    // no-reply expiry, then reply before expiry
    wr(`RPT_OFF_CTRL, 32'h0);
    wr(`RPT_OFF_MRT, 32'h0);
    wr(`RPT_OFF_NRT2, 32'h1);
    pulse(5'h01);
    flags(80, 32'h1);
    chk(32'(rx_window_o), 32'h0);
    wr(`RPT_OFF_NRT2, 32'h2);
    pulse(5'h01);
    cyc(3);
    chk(32'(rx_window_o), 32'h1);
    pulse(5'h02);
    flags(200, 32'h0);
    // coarse step, then a count from both bytes
    wr(`RPT_OFF_TCTRL, 32'h2);
    pulse(5'h01);
    flags(3900, 32'h0);
    flags(4500, 32'h1);
    wr(`RPT_OFF_TCTRL, 32'h0);
    wr(`RPT_OFF_NRT1, 32'h1);
    wr(`RPT_OFF_NRT2, 32'h0);
    pulse(5'h01);
    flags(16000, 32'h0);
    flags(600, 32'h1);
    // unconditional mode ignores reply start and clear
    wr(`RPT_OFF_NRT1, 32'h0);
    wr(`RPT_OFF_NRT2, 32'h1);
    wr(`RPT_OFF_TCTRL, 32'h1);
    rx_busy_i <= 1'b1;
    pulse(5'h01);
    pulse(5'h02);
    wr(`RPT_OFF_CMD, 32'h1);
    flags(80, 32'h1);
    chk(32'(rx_window_o), 32'h1);
    rx_busy_i <= 1'b0;
    pulse(5'h01);
    flags(80, 32'h1);
    chk(32'(rx_window_o), 32'h0);
    wr(`RPT_OFF_TCTRL, 32'h0);
    wr(`RPT_OFF_NRT2, 32'h0);
    pulse(5'h01);
    // general timer: clear, restart, triggers, frozen crystal
    wr(`RPT_OFF_GPT, 32'h3);
    wr(`RPT_OFF_CMD, 32'h8);
    wr(`RPT_OFF_CMD, 32'h1);
    flags(100, 32'h0);
    wr(`RPT_OFF_CMD, 32'h8);
    cyc(100);
    wr(`RPT_OFF_CMD, 32'h8);
    flags(110, 32'h0);
    flags(100, 32'h2);
    wr(`RPT_OFF_GPT, 32'h1);
    for (int t = 1; t < 4; t++) begin
      wr(`RPT_OFF_CTRL, 32'(t == 3));
      wr(`RPT_OFF_TCTRL, 32'(t << 2));
      pulse(5'(1 << (t == 3 ? 4 : t)));
      flags(80, 32'h2);
    end
    wr(`RPT_OFF_TCTRL, 32'h0);
    wr(`RPT_OFF_CTRL, 32'h0);
    pulse(5'h16);
    flags(80, 32'h0);
    xtal_ok_i <= 1'b0;
    wr(`RPT_OFF_CMD, 32'h8);
    flags(150, 32'h0);
    xtal_ok_i <= 1'b1;
    flags(80, 32'h2);
    // peer mode
    wr(`RPT_OFF_CTRL, 32'h1);
    wr(`RPT_OFF_MRT, 32'h1);
    pulse(5'h01);
    cyc(3);
    chk(32'(rx_window_o), 32'h1);
    pulse(5'h08);
    cyc(3);
    chk(32'(rx_window_o), 32'h0);
    cyc(80);
    wr(`RPT_OFF_NRT2, 32'h1);
    wr(`RPT_OFF_CMD, 32'h4);
    rd_chk(`RPT_OFF_STATUS, 32'h10);
    pulse(5'h01);
    flags(80, 32'h1);
    // wake timer: refused in wake mode, survives clear
    wr(`RPT_OFF_CTRL, 32'h4);
    wr(`RPT_OFF_WUCTRL, 32'h0);
    wr(`RPT_OFF_CMD, 32'h10);
    cyc(3);
    chk(32'(rc_osc_en_o), 32'h0);
    wr(`RPT_OFF_CTRL, 32'h0);
    wr(`RPT_OFF_CMD, 32'h10);
    wr(`RPT_OFF_CMD, 32'h1);
    chk(32'(rc_osc_en_o), 32'h1);
    flags(280, 32'h0);
    flags(60, 32'h4);
    finish_test;
  end
endmodule
